/* File: rtl/rpm_params.svh */
// Timing counts and fixed values for the reset pin and mode select block.
// Assumes a single bus clock; all counts are in bus clock or debug clock cycles.
`ifndef RPM_PARAMS_SVH
`define RPM_PARAMS_SVH

// ============================================================
// Reset pin sequencing
`define RPM_DRIVE_CYCLES  6'd34
`define RPM_WAIT_CYCLES   6'd38

// ============================================================
// Single-wire debug bit timing, in debug clock ticks
`define RPM_BIT_TICKS     5'd16
`define RPM_TX1_LOW_TICKS 5'd4
`define RPM_TX0_LOW_TICKS 5'd13
`define RPM_RX_SAMPLE     5'd10

// ============================================================
// Reset vector location
`define RPM_RESET_VECTOR  16'hfffe

`endif

/* File: rtl/rpm_pkg.sv */
// Types shared by the reset pin and mode select block.
// Assumes rpm_params.svh supplies all numeric constants.
package rpm_pkg;

    typedef enum logic [1:0] {
        RPM_RST_DRIVE  = 2'b00,
        RPM_RST_WAIT   = 2'b01,
        RPM_RST_SAMPLE = 2'b10,
        RPM_RST_RUN    = 2'b11
    } rpm_rst_state_t;

    typedef enum logic [1:0] {
        RPM_BIT_IDLE = 2'b00,
        RPM_BIT_TX   = 2'b01,
        RPM_BIT_RX   = 2'b10
    } rpm_bit_state_t;

    // Internal reset requests, one-cycle or level, from bus-clock logic.
    typedef struct packed {
        logic lvd;
        logic cop;
        logic ilop;
        logic bdfr;
    } rpm_rst_src_t;

    // Reset cause record.
    typedef struct packed {
        logic por;
        logic pin;
        logic lvd;
        logic cop;
        logic ilop;
        logic bdfr;
    } rpm_cause_t;

    // Drive of a pseudo open-drain pin.
    typedef struct packed {
        logic data;
        logic oe;
    } rpm_pin_t;

endpackage

/* File: rtl/rpm_bit_timer.sv */
// Single-wire debug bit engine: one bit per 16 debug clock ticks.
// Assumes line_in is already synchronised and tick_in is a bus-clock strobe.
`timescale 1ns/1ps
`include "rpm_params.svh"

module rpm_bit_timer (
    input  wire logic          clk_sys_in,
    input  wire logic          arst_n_in,
    input  wire logic          enable_in,
    input  wire logic          tick_in,
    input  wire logic          line_in,
    input  wire logic          tx_req_in,
    input  wire logic          tx_bit_in,
    output logic               tx_ready_out,
    output logic               rx_valid_out,
    output logic               rx_bit_out,
    output rpm_pkg::rpm_pin_t  pin_out
);
    import rpm_pkg::*;

    rpm_bit_state_t state_q;
    logic [4:0]     cnt_q;
    logic [4:0]     low_len_q;
    logic           line_prev_q;
    logic           fall;
    logic           last_tick;

    assign fall         = line_prev_q & ~line_in;
    assign last_tick    = tick_in && (cnt_q == `RPM_BIT_TICKS - 5'd1);
    // A send starts only on a tick, so the first tick of the bit lasts a full period.
    assign tx_ready_out = enable_in && tick_in && (state_q == RPM_BIT_IDLE);

    // ============================================================
    // Edge detection
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            line_prev_q <= 1'b1;
        end else begin
            line_prev_q <= line_in;
        end
    end

    // ============================================================
    // Bit sequencing
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q   <= RPM_BIT_IDLE;
            cnt_q     <= 5'h00;
            low_len_q <= 5'h00;
        end else if (!enable_in) begin
            state_q <= RPM_BIT_IDLE;
            cnt_q   <= 5'h00;
        end else begin
            case (state_q)
                RPM_BIT_IDLE: begin
                    cnt_q <= 5'h00;
                    if (tx_req_in && tick_in) begin
                        state_q   <= RPM_BIT_TX;
                        low_len_q <= tx_bit_in ? `RPM_TX1_LOW_TICKS : `RPM_TX0_LOW_TICKS;
                    end else if (fall) begin
                        state_q <= RPM_BIT_RX;
                    end
                end
                RPM_BIT_TX, RPM_BIT_RX: begin
                    if (last_tick) begin
                        state_q <= RPM_BIT_IDLE;
                        cnt_q   <= 5'h00;
                    end else if (tick_in) begin
                        cnt_q <= cnt_q + 5'd1;
                    end
                end
                default: begin
                    state_q <= RPM_BIT_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Receive sampling
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_valid_out <= 1'b0;
            rx_bit_out   <= 1'b0;
        end else begin
            rx_valid_out <= 1'b0;
            if (enable_in && state_q == RPM_BIT_RX && tick_in && cnt_q == `RPM_RX_SAMPLE) begin
                rx_valid_out <= 1'b1;
                rx_bit_out   <= line_in;
            end
        end
    end

    // ============================================================
    // Line drive
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_out <= '0;
        end else if (enable_in && state_q == RPM_BIT_TX && !last_tick) begin
            pin_out.oe   <= (cnt_q <= low_len_q);
            pin_out.data <= (cnt_q == low_len_q);
        end else begin
            pin_out <= '0;
        end
    end

endmodule // rpm_bit_timer

/* File: rtl/rpm_top.sv */
// Reset pin sequencer, reset cause record and boot mode select.
// Assumes internal reset requests and the local clock strobe come from
// bus-clock logic; both pins arrive asynchronously.
//
// Overview of operation
// - On any reset drive the reset pin low 34 bus cycles, then release.
// - After release wait 38 bus cycles, then sample the reset pin again.
// - After an internal reset the delayed reset pin sample is expected high.
// - Decode each reset source and set its bit in the cause register; an internal request drops a pin request of the same cycle.
// - An outside party holding the reset pin low puts the device in reset.
// - Debug pin is mode select during reset, debug link straight after.
// - Mode select high at reset release starts normal run mode.
// - Each debug bit time lasts 16 debug clock cycles.
// - Debug clock may run at the full bus clock rate.
// - Host may choose the local self clock of about 8 MHz for debug.
// - Debug pin is pseudo open-drain with a brief driven-high speedup pulse.
// - Normal run mode begins at the address held in the reset vector.
`timescale 1ns/1ps
`include "rpm_params.svh"

module rpm_top (
    input  wire logic                 clk_sys_in,
    input  wire logic                 arst_n_in,
    input  wire logic                 reset_pin_in,
    output logic                      reset_pin_out,
    output logic                      reset_pin_oe_out,
    input  wire rpm_pkg::rpm_rst_src_t int_reset_req_in,
    input  wire logic                 debug_mode_select_pin_in,
    output logic                      single_wire_debug_pin_out,
    output logic                      single_wire_debug_pin_oe_out,
    input  wire logic                 dbg_clk_sel_in,
    input  wire logic                 local_self_clock_tick_in,
    input  wire logic                 dbg_tx_req_in,
    input  wire logic                 dbg_tx_bit_in,
    output logic                      dbg_tx_ready_out,
    output logic                      dbg_rx_valid_out,
    output logic                      dbg_rx_bit_out,
    output logic                      sys_reset_n_out,
    output logic                      bgnd_mode_out,
    output logic                      vector_fetch_out,
    output logic [15:0]               vector_addr_out,
    output rpm_pkg::rpm_cause_t       reset_cause_register_out
);
    import rpm_pkg::*;

    rpm_rst_state_t state_q;
    logic [5:0]     cnt_q;
    logic           rst_meta_q;
    logic           rst_sync_q;
    logic           ms_meta_q;
    logic           ms_sync_q;
    logic           int_req;
    logic           pin_req;
    logic           sample_ok;
    logic           run_q;
    logic           bgnd_q;
    logic           fetch_q;
    logic           dbg_tick;
    rpm_cause_t     cause_q;
    rpm_pin_t       dbg_pin;

    // Reset request from internal sources, only acted on while running.
    function automatic rpm_cause_t int_cause(input rpm_rst_src_t src);
        rpm_cause_t c;
        c      = '0;
        c.lvd  = src.lvd;
        c.cop  = src.cop;
        c.ilop = src.ilop;
        c.bdfr = src.bdfr;
        return c;
    endfunction

    assign int_req   = |int_reset_req_in;
    assign pin_req   = ~rst_sync_q;
    assign sample_ok = (state_q == RPM_RST_SAMPLE) && rst_sync_q;

    // ============================================================
    // Pin synchronisers
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= 1'b1;
            ms_meta_q  <= 1'b1;
            ms_sync_q  <= 1'b1;
        end else begin
            rst_meta_q <= reset_pin_in;
            rst_sync_q <= rst_meta_q;
            ms_meta_q  <= debug_mode_select_pin_in;
            ms_sync_q  <= ms_meta_q;
        end
    end

    // ============================================================
    // Reset sequencer
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= RPM_RST_DRIVE;
            cnt_q   <= 6'h00;
        end else begin
            case (state_q)
                RPM_RST_DRIVE: begin
                    if (cnt_q == `RPM_DRIVE_CYCLES - 6'd1) begin
                        state_q <= RPM_RST_WAIT;
                        cnt_q   <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'd1;
                    end
                end
                RPM_RST_WAIT: begin
                    if (cnt_q == `RPM_WAIT_CYCLES - 6'd1) begin
                        state_q <= RPM_RST_SAMPLE;
                        cnt_q   <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'd1;
                    end
                end
                RPM_RST_SAMPLE: begin
                    if (rst_sync_q) begin
                        state_q <= RPM_RST_RUN;
                    end
                end
                RPM_RST_RUN: begin
                    if (int_req || pin_req) begin
                        state_q <= RPM_RST_DRIVE;
                        cnt_q   <= 6'h00;
                    end
                end
                default: begin
                    state_q <= RPM_RST_DRIVE;
                    cnt_q   <= 6'h00;
                end
            endcase
        end
    end

    assign reset_pin_out    = 1'b0;
    assign reset_pin_oe_out = (state_q == RPM_RST_DRIVE);

    // ============================================================
    // Reset cause record
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cause_q     <= '0;
            cause_q.por <= 1'b1;
        end else if (state_q == RPM_RST_RUN && int_req) begin
            cause_q <= int_cause(int_reset_req_in);
        end else if (state_q == RPM_RST_RUN && pin_req) begin
            cause_q     <= '0;
            cause_q.pin <= 1'b1;
        end else if (state_q == RPM_RST_SAMPLE && !rst_sync_q) begin
            cause_q.pin <= 1'b1;
        end
    end

    assign reset_cause_register_out = cause_q;

    // ============================================================
    // Mode capture and release of internal reset
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            run_q   <= 1'b0;
            bgnd_q  <= 1'b0;
            fetch_q <= 1'b0;
        end else begin
            fetch_q <= 1'b0;
            if (sample_ok) begin
                run_q   <= 1'b1;
                bgnd_q  <= ~ms_sync_q;
                fetch_q <= ms_sync_q;
            end else if (state_q != RPM_RST_RUN || int_req || pin_req) begin
                run_q <= 1'b0;
            end
        end
    end

    assign sys_reset_n_out  = run_q;
    assign bgnd_mode_out    = bgnd_q;
    assign vector_fetch_out = fetch_q;
    assign vector_addr_out  = `RPM_RESET_VECTOR;

    // ============================================================
    // Single-wire debug link
    // Bus rate, local self clock
    assign dbg_tick = dbg_clk_sel_in ? local_self_clock_tick_in : 1'b1;

    rpm_bit_timer u_bit_timer (
        .clk_sys_in   (clk_sys_in),
        .arst_n_in    (arst_n_in),
        .enable_in    (run_q),
        .tick_in      (dbg_tick),
        .line_in      (ms_sync_q),
        .tx_req_in    (dbg_tx_req_in),
        .tx_bit_in    (dbg_tx_bit_in),
        .tx_ready_out (dbg_tx_ready_out),
        .rx_valid_out (dbg_rx_valid_out),
        .rx_bit_out   (dbg_rx_bit_out),
        .pin_out      (dbg_pin)
    );

    assign single_wire_debug_pin_out    = dbg_pin.data;
    assign single_wire_debug_pin_oe_out = dbg_pin.oe;

endmodule // rpm_top

/* File: verif/rpm_top_assertions.sv */
// Port timing checker for rpm_top.
// Assumes it is bound to every rpm_top instance by the bind below.
`timescale 1ns/1ps
module rpm_top_checker (
    input wire logic                  clk_sys_in,
    input wire logic                  arst_n_in,
    input wire logic                  reset_pin_in,
    input wire logic                  reset_pin_oe_out,
    input wire rpm_pkg::rpm_rst_src_t int_reset_req_in,
    input wire logic                  debug_mode_select_pin_in,
    input wire logic                  single_wire_debug_pin_out,
    input wire logic                  single_wire_debug_pin_oe_out,
    input wire logic                  dbg_clk_sel_in,
    input wire logic                  dbg_tx_req_in,
    input wire logic                  dbg_tx_ready_out,
    input wire logic                  dbg_rx_valid_out,
    input wire logic                  sys_reset_n_out,
    input wire logic                  bgnd_mode_out,
    input wire logic                  vector_fetch_out,
    input wire logic [15:0]           vector_addr_out,
    input wire rpm_pkg::rpm_cause_t   reset_cause_register_out
);
    import rpm_pkg::*;
    logic [7:0] oe_cnt_q;
    logic [7:0] rel_cnt_q;
    logic [7:0] low_cnt_q;
    wire        dbg_low = single_wire_debug_pin_oe_out && !single_wire_debug_pin_out;
    wire        dbg_high = single_wire_debug_pin_oe_out && single_wire_debug_pin_out;

    // ============================================================
    // Run lengths of the reset pin drive, the release wait and a debug low pulse
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            oe_cnt_q  <= 8'h00;
            rel_cnt_q <= 8'h00;
            low_cnt_q <= 8'h00;
        end else begin
            oe_cnt_q  <= reset_pin_oe_out ? oe_cnt_q + 8'h01 : 8'h00;
            rel_cnt_q <= (reset_pin_oe_out || sys_reset_n_out) ? 8'h00 :
                         (rel_cnt_q == 8'hff) ? rel_cnt_q : rel_cnt_q + 8'h01;
            low_cnt_q <= dbg_low ? low_cnt_q + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);

    // ============================================================
    // Assertions
    AST_DRIVE_LEN: assert property (!reset_pin_oe_out && oe_cnt_q != 8'h00
        |-> oe_cnt_q == 8'h22) else $error("reset pin drive length wrong");
    AST_WAIT_LEN: assert property ($rose(sys_reset_n_out)
        |-> rel_cnt_q >= 8'h26) else $error("reset released too early");
    AST_PIN_ENTRY: assert property (sys_reset_n_out && !reset_pin_in
        |-> ##[1:4] !sys_reset_n_out) else $error("pin low did not reset");
    AST_INT_ENTRY: assert property (sys_reset_n_out && int_reset_req_in != '0
        |=> reset_pin_oe_out && !sys_reset_n_out
        && reset_cause_register_out == {2'b00, $past(int_reset_req_in)})
        else $error("internal reset entry or cause wrong");
    AST_MODE: assert property ($rose(sys_reset_n_out)
        && $past(debug_mode_select_pin_in, 3) == $past(debug_mode_select_pin_in)
        |-> bgnd_mode_out == !$past(debug_mode_select_pin_in)
        && vector_fetch_out == $past(debug_mode_select_pin_in))
        else $error("mode select not honoured");
    AST_FETCH: assert property (vector_fetch_out
        |-> $rose(sys_reset_n_out) && vector_addr_out == 16'hfffe ##1 !vector_fetch_out)
        else $error("vector fetch wrong");
    AST_LINK_IDLE: assert property (!sys_reset_n_out && !$past(sys_reset_n_out)
        |-> !single_wire_debug_pin_oe_out && !dbg_tx_ready_out && !dbg_rx_valid_out)
        else $error("debug link active in reset");
    AST_BIT_TIME: assert property (!dbg_clk_sel_in && dbg_tx_req_in && dbg_tx_ready_out
        |=> !dbg_tx_ready_out ##15 !dbg_tx_ready_out ##1 dbg_tx_ready_out)
        else $error("debug bit time wrong");
    AST_LOW_LEN: assert property ($rose(dbg_high) && !dbg_clk_sel_in
        |-> low_cnt_q == 8'h04 || low_cnt_q == 8'h0d) else $error("debug low pulse wrong");
    AST_SPEEDUP: assert property (!dbg_clk_sel_in && dbg_high
        |=> !single_wire_debug_pin_oe_out) else $error("speedup pulse too long");

    COV_RUN: cover property (vector_fetch_out);
    COV_BGND: cover property ($rose(bgnd_mode_out));
    COV_RX: cover property (dbg_rx_valid_out);
endmodule // rpm_top_checker

bind rpm_top rpm_top_checker i_rpm_top_checker (.*);

/* File: verif/rpm_host_model.sv */
// Debug host and manual reset switch facing the rpm_top pins.
// Assumes both lines have pullups and the bench drives controls at the rising edge.
`timescale 1ns/1ps
module rpm_host_model (
    input  wire logic clk_sys_in,
    input  wire logic rst_data_in,
    input  wire logic rst_oe_in,
    input  wire logic dbg_data_in,
    input  wire logic dbg_oe_in,
    input  wire logic switch_low_in,
    input  wire logic ms_low_in,
    output logic      reset_line_out,
    output logic      dbg_line_out
);
    logic tx_low = 1'b0;
    logic tx_high = 1'b0;
    int   low_run = 0;
    int   last_low = 0;
    assign reset_line_out = !((rst_oe_in && !rst_data_in) || switch_low_in);
    assign dbg_line_out = dbg_oe_in ? dbg_data_in : (tx_high || !(tx_low || ms_low_in));

    // Length of the last low pulse the device drove before its speedup.
    always @(posedge clk_sys_in) begin
        if (dbg_oe_in && !dbg_data_in) begin
            low_run <= low_run + 1;
        end else if (dbg_oe_in && low_run != 0) begin
            last_low <= low_run;
            low_run <= 0;
        end
    end

    // one bit of 16 periods of per clocks: low, one speedup period, then released high
    task automatic send_bit(input logic b, input int per);
        tx_low <= 1'b1;
        repeat ((b ? 4 : 13) * per) @(posedge clk_sys_in);
        tx_low <= 1'b0;
        tx_high <= 1'b1;
        repeat (per) @(posedge clk_sys_in);
        tx_high <= 1'b0;
        repeat ((b ? 11 : 2) * per) @(posedge clk_sys_in);
    endtask
endmodule // rpm_host_model

/* File: verif/test_reset_pin_and_mode_select.sv */
// Self-checking bench for rpm_top with the host and switch model.
// Assumes rpm_top, rpm_host_model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_reset_pin_and_mode_select;
    import rpm_pkg::*;
    logic          clk_sys_in = 1'b0;
    logic          arst_n_in = 1'b0;
    logic          reset_pin_in, reset_pin_out, reset_pin_oe_out;
    rpm_rst_src_t  int_reset_req_in = '0;
    logic          debug_mode_select_pin_in;
    logic          single_wire_debug_pin_out, single_wire_debug_pin_oe_out;
    logic          dbg_clk_sel_in = 1'b0;
    logic          local_self_clock_tick_in = 1'b0;
    logic          dbg_tx_req_in = 1'b0;
    logic          dbg_tx_bit_in = 1'b0;
    logic          dbg_tx_ready_out, dbg_rx_valid_out, dbg_rx_bit_out;
    logic          sys_reset_n_out, bgnd_mode_out, vector_fetch_out;
    logic [15:0]   vector_addr_out;
    rpm_cause_t    reset_cause_register_out;
    logic          sw_low = 1'b0;
    logic          ms_low = 1'b0;
    logic [1:0]    tdiv = 2'h0;
    int            errors = 0;
    int            n_tests = 0;
    int            cyc = 0;

    rpm_top i_rpm_top (.*);
    rpm_host_model i_rpm_host_model (.clk_sys_in(clk_sys_in), .rst_data_in(reset_pin_out),
        .rst_oe_in(reset_pin_oe_out), .dbg_data_in(single_wire_debug_pin_out),
        .dbg_oe_in(single_wire_debug_pin_oe_out), .switch_low_in(sw_low),
        .ms_low_in(ms_low), .reset_line_out(reset_pin_in),
        .dbg_line_out(debug_mode_select_pin_in));

    always #20 clk_sys_in = ~clk_sys_in;

    // local self clock strobe, one bus cycle in three
    always @(posedge clk_sys_in) begin
        tdiv <= (tdiv == 2'h2) ? 2'h0 : tdiv + 2'h1;
        local_self_clock_tick_in <= (tdiv == 2'h2);
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            errors++;
            complete_run();
        end
    end

    // ============================================================
    // Helpers
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rst_seq(input logic [5:0] ec, input logic ms);
        int a, w;
        a = 0;
        w = 0;
        do begin @(negedge clk_sys_in); w++; end while (reset_pin_oe_out !== 1'b1 && w < 10);
        w = 0;
        while (reset_pin_oe_out === 1'b1 && a < 99) begin @(negedge clk_sys_in); a++; end
        while (sys_reset_n_out !== 1'b1 && w < 999) begin @(negedge clk_sys_in); w++; end
        chk("drive cycles", 16'(a), 16'd34);
        chk("release wait", 16'(w == 38 || w == 39), 16'h1);
        chk("cause", 16'(reset_cause_register_out), 16'(ec));
        chk("bgnd mode", 16'(bgnd_mode_out), 16'(!ms));
        chk("fetch", 16'(vector_fetch_out), 16'(ms));
        chk("vector", vector_addr_out, 16'hfffe);
    endtask

    task automatic tx(input logic b, input int per);
        int w;
        w = 0;
        @(posedge clk_sys_in);
        dbg_tx_req_in <= 1'b1;
        dbg_tx_bit_in <= b;
        do begin @(negedge clk_sys_in); w++; end while (dbg_tx_ready_out !== 1'b1 && w < 99);
        @(posedge clk_sys_in);
        dbg_tx_req_in <= 1'b0;
        @(negedge clk_sys_in);
        w = 0;
        while (dbg_tx_ready_out !== 1'b1 && w < 999) begin @(negedge clk_sys_in); w++; end
        chk("tx low", 16'(i_rpm_host_model.last_low), 16'((b ? 4 : 13) * per));
    endtask

    // ============================================================
    // Scenarios
    task automatic t_internal();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_in);
            int_reset_req_in <= 4'h8 >> i;
            @(posedge clk_sys_in);
            int_reset_req_in <= '0;
            rst_seq(6'(4'h8 >> i), 1'b1);
        end
        $display("internal resets done");
    endtask

    task automatic t_pin_and_mode();
        int w;
        @(posedge clk_sys_in);
        sw_low <= 1'b1;
        fork
            rst_seq(6'h10, 1'b1);
            begin
                repeat (10) @(posedge clk_sys_in);
                sw_low <= 1'b0;
            end
        join
        @(posedge clk_sys_in);
        sw_low <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        ms_low <= 1'b1;
        repeat (150) @(posedge clk_sys_in);
        chk("held in reset", 16'(sys_reset_n_out), 16'h0);
        sw_low <= 1'b0;
        w = 0;
        while (sys_reset_n_out !== 1'b1 && w < 99) begin @(negedge clk_sys_in); w++; end
        chk("bgnd entry", 16'({bgnd_mode_out, vector_fetch_out}), 16'h2);
        chk("pin cause", 16'(reset_cause_register_out.pin), 16'h1);
        @(posedge clk_sys_in);
        ms_low <= 1'b0;
        $display("pin reset and mode select done");
    endtask

    task automatic t_link();
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_sys_in);
            dbg_clk_sel_in <= s[0];
            tx(1'b1, s ? 3 : 1);
            tx(1'b0, s ? 3 : 1);
        end
        @(posedge clk_sys_in);
        dbg_clk_sel_in <= 1'b0;
        for (int k = 1; k >= 0; k--) begin
            fork
                i_rpm_host_model.send_bit(k[0], 1);
                begin
                    while (dbg_rx_valid_out !== 1'b1 && cyc < 5900) @(negedge clk_sys_in);
                    chk("rx bit", 16'(dbg_rx_bit_out), 16'(k));
                end
            join
            repeat (4) @(posedge clk_sys_in);
        end
        $display("debug link done");
    endtask

    task complete_run;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        rst_seq(6'h20, 1'b1);
        $display("power up done");
        t_internal();
        t_pin_and_mode();
        t_link();
        complete_run();
    end
endmodule // test_reset_pin_and_mode_select
